// File: dv/bbd_mem_model.sv
// Program and data memory model facing the decoder core
`timescale 1ns/10ps
`default_nettype none
module bbd_mem_model
    import bbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic [11:0] pm_addr_i,
    input wire bbd_dm_req_t dm_req_i,
    output logic [7:0] pm_data_o,
    output logic [7:0] dm_rdata_o
);
    // ==========================================================
    // Memories
    logic [7:0] pm [4096];
    logic [7:0] dm [256];

    // Both answer in the same cycle, as the core samples them at the edge
    assign pm_data_o = pm[pm_addr_i];
    assign dm_rdata_o = dm[dm_req_i.addr];

    // Plain RAM only: a whole-byte rewrite is harmless here, unlike on port registers
    always @(posedge clk_i) begin
        if (dm_req_i.we === 1'b1) begin
            dm[dm_req_i.addr] <= dm_req_i.wdata;
        end
    end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the branch, bit and control decoder core
`timescale 1ns/10ps
`default_nettype none
module testbench
    import bbd_pkg::*;
;
    // ==========================================================
    // Signals
    localparam logic [2:0] BIT_OF [8] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h5, 3'h3, 3'h7};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wdog_sel_i = 1'b0;
    logic wake_i = 1'b0;
    logic ext_done_i = 1'b0;
    logic [11:0] ext_pc_i = 12'h000;
    bbd_flags_t interrupt_exit_instr_flags_i = '0;
    logic [7:0] pm_data_i, dm_rdata_i, opcode_o;
    logic [11:0] pm_addr_o;
    bbd_dm_req_t dm_req_o;
    bbd_flags_t flags_o;
    logic illegal_o, halt_o, idle_o, foreign_o;
    int err_total = 0;
    int n_compared = 0;
    int n_cyc = 0;
    int n_pulse [4] = '{0, 0, 0, 0};

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    bbd_core i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pm_data_i(pm_data_i),
        .dm_rdata_i(dm_rdata_i), .wdog_sel_i(wdog_sel_i), .wake_i(wake_i),
        .ext_done_i(ext_done_i), .ext_pc_i(ext_pc_i), .interrupt_exit_instr_flags_i(interrupt_exit_instr_flags_i),
        .pm_addr_o(pm_addr_o), .dm_req_o(dm_req_o), .flags_o(flags_o), .opcode_o(opcode_o),
        .illegal_o(illegal_o), .halt_o(halt_o), .idle_o(idle_o), .foreign_o(foreign_o));
    bbd_mem_model i_mem (.clk_i(clk_i), .pm_addr_i(pm_addr_o), .dm_req_i(dm_req_o),
        .pm_data_o(pm_data_i), .dm_rdata_o(dm_rdata_i));

    // ==========================================================
    // Reporting and helpers
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Pulse counters and the hang guard; the run needs about 910 cycles
    always @(posedge clk_i) begin
        n_cyc++;
        if (illegal_o === 1'b1) n_pulse[0]++;
        if (halt_o === 1'b1) n_pulse[1]++;
        if (idle_o === 1'b1) n_pulse[2]++;
        if (foreign_o === 1'b1) n_pulse[3]++;
        if (n_cyc == 4000) begin
            fail("timeout");
            tally_and_finish();
        end
    end

    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic cmp_pc(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) fail($sformatf("address %h want %h", got, exp));
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) fail($sformatf("byte %h want %h", got, exp));
    endtask
    task automatic cmp_flags(input bbd_flags_t got, input bbd_flags_t exp);
        n_compared++;
        if (got !== exp) fail($sformatf("flags %b want %b", got, exp));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Call to 080h whose interrupt exit loads the flags and returns to 002h: six cycles
    task automatic setup(input bbd_flags_t f);
        rst_n_i = 1'b0;
        for (int a = 0; a < 4096; a++) i_mem.pm[a] = 8'h77;
        i_mem.pm[0] = 8'h01;
        i_mem.pm[1] = 8'h80;
        i_mem.pm[12'h080] = OPC_INT_EXIT;
        interrupt_exit_instr_flags_i = f;
        tick(5);
    endtask
    task automatic start();
        rst_n_i = 1'b1;
        n_pulse = '{0, 0, 0, 0};
    endtask
    // Land at the start of cycle n: next fetch address shown, opcode not yet replaced
    task automatic go(input int n, input logic [11:0] pc, input logic [7:0] last);
        start();
        tick(n);
        cmp_pc(pm_addr_o, pc);
        cmp_byte(opcode_o, last);
    endtask
    task automatic marker();
        tick(1);
        cmp_byte(opcode_o, OPC_NOP);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_flag_branch();
        logic [7:0] op;
        logic [4:0] e;
        logic [11:0] tgt;
        logic hit;
        bbd_flags_t f;
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 2; k++) begin
                e = k[0] ? 5'h10 : 5'h0e;
                f = {k[0], ~k[0]};
                op = {e, c[1:0], 1'b0};
                hit = (c == 0) ? !f.z : (c == 1) ? !f.c : (c == 2) ? f.z : f.c;
                tgt = hit ? 12'h003 + {{7{e[4]}}, e} : 12'h003;
                setup(f);
                i_mem.pm[2] = op;
                i_mem.pm[tgt] = OPC_NOP;
                go(8, tgt, op);
                cmp_flags(flags_o, f);
                marker();
            end
        end
        $display("flag branch test done");
    endtask

    task automatic t_bit_test();
        logic [7:0] op, ee;
        logic [11:0] tgt;
        logic [2:0] b;
        logic v;
        for (int h = 0; h < 16; h++) begin
            op = {h[3:0], 4'h3};
            b = BIT_OF[h / 2];
            v = h[1];
            ee = h[2] ? 8'h82 : 8'h10;
            tgt = (v == h[0]) ? 12'h004 + {{4{ee[7]}}, ee} : 12'h005;
            setup(2'b10);
            i_mem.pm[2] = op;
            i_mem.pm[3] = 8'h20;
            i_mem.pm[4] = ee;
            i_mem.pm[tgt] = OPC_NOP;
            i_mem.dm[8'h20] = v ? (8'h01 << b) : ~(8'h01 << b);
            go(11, tgt, op);
            cmp_flags(flags_o, {1'b1, v});
            marker();
        end
        $display("bit test branch test done");
    endtask

    task automatic t_bit_op();
        logic [7:0] op, a, d, exp;
        logic [2:0] b;
        for (int h = 0; h < 16; h++) begin
            op = {h[3:0], 4'hb};
            b = BIT_OF[h / 2];
            a = {4'hc, h[3:0]};
            d = 8'h5a ^ {8{h[2]}};
            exp = h[0] ? (d | (8'h01 << b)) : (d & ~(8'h01 << b));
            setup(2'b01);
            i_mem.pm[2] = op;
            i_mem.pm[3] = a;
            i_mem.pm[4] = OPC_NOP;
            i_mem.dm[a] = d;
            go(10, 12'h004, op);
            cmp_byte(dm_req_o.addr, a);
            cmp_byte(dm_req_o.wdata, exp);
            cmp_byte({7'h00, dm_req_o.we}, 8'h01);
            cmp_flags(flags_o, 2'b01);
            marker();
            cmp_byte({7'h00, dm_req_o.we}, 8'h00);
            cmp_byte(i_mem.dm[a], exp);
        end
        $display("bit set and clear test done");
    endtask

    task automatic t_jump_call();
        setup(2'b11);
        i_mem.pm[2] = 8'hf9;
        i_mem.pm[3] = 8'hab;
        i_mem.pm[12'hfab] = 8'h31;
        i_mem.pm[12'hfac] = 8'hc0;
        i_mem.pm[12'h3c0] = OPC_SUB_EXIT;
        i_mem.pm[12'hfad] = OPC_NOP;
        go(10, 12'hfab, 8'hf9);
        cmp_flags(flags_o, 2'b11);
        tick(4);
        cmp_pc(pm_addr_o, 12'h3c0);
        tick(2);
        cmp_pc(pm_addr_o, 12'hfad);
        cmp_flags(flags_o, 2'b11);
        marker();
        $display("jump and call test done");
    endtask

    task automatic t_sleep();
        logic [7:0] op;
        for (int k = 0; k < 3; k++) begin
            op = (k == 2) ? OPC_IDLE : OPC_HALT;
            wdog_sel_i = (k == 1);
            setup(2'b10);
            i_mem.pm[2] = op;
            i_mem.pm[3] = OPC_NOP;
            start();
            tick(14);
            cmp_byte(8'(n_pulse[1]), (k == 0) ? 8'h01 : 8'h00);
            cmp_byte(8'(n_pulse[2]), (k == 0) ? 8'h00 : 8'h01);
            cmp_byte(opcode_o, op);
            cmp_flags(flags_o, 2'b10);
            wake_i = 1'b1;
            tick(2);
            wake_i = 1'b0;
            cmp_byte(opcode_o, OPC_NOP);
        end
        wdog_sel_i = 1'b0;
        $display("halt and idle test done");
    endtask

    task automatic t_skip();
        logic [7:0] ops [12] = '{8'h05, 8'h25, 8'h45, 8'h65, 8'h85, 8'ha5, 8'hc5, 8'he5,
            8'h77, 8'h97, 8'hf7, OPC_NOP};
        foreach (ops[i]) begin
            setup(2'b01);
            i_mem.pm[2] = ops[i];
            i_mem.pm[3] = OPC_NOP;
            go(8, 12'h003, ops[i]);
            cmp_flags(flags_o, 2'b01);
            marker();
            cmp_byte(8'(n_pulse[0]), (i == 11) ? 8'h00 : 8'h01);
            cmp_byte(8'(n_pulse[3]), 8'h00);
        end
        $display("illegal and no-op test done");
    endtask

    task automatic t_foreign();
        setup(2'b00);
        i_mem.pm[2] = 8'h17;
        i_mem.pm[12'h234] = OPC_NOP;
        start();
        tick(12);
        cmp_byte(8'(n_pulse[3]), 8'h01);
        cmp_byte(8'(n_pulse[0]), 8'h00);
        ext_pc_i = 12'h234;
        ext_done_i = 1'b1;
        tick(1);
        ext_done_i = 1'b0;
        tick(1);
        cmp_byte(opcode_o, OPC_NOP);
        $display("foreign opcode test done");
    endtask

    initial begin
        t_flag_branch();
        t_bit_test();
        t_bit_op();
        t_jump_call();
        t_sleep();
        t_skip();
        t_foreign();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: hw/bbd_core.sv
// Decode and execute of branch, bit, control, long jump and call instructions
// Contract
// RL1: Flag branches are one byte, take two cycles, jump on C=1, C=0, Z=1 or Z=0, keep flags.
// RL2: Flag branches carry a 5-bit signed offset reaching -15 to +16 from the opcode.
// RL3: Bit-test branches are three bytes, five cycles, test one data byte bit, 8-bit offset.
// RL4: A bit-test branch copies the tested bit into carry and keeps zero.
// RL5: Bit instructions pick the bit with a 3-bit field held in the opcode.
// RL6: Bit set and clear reach any data bit, are two bytes, four cycles, keep flags.
// RL7: Software should not use bit set or clear on port data or partly read-only registers.
// RL8: No-op, both exits, halt and idle are one byte, two cycles; only interrupt exit sets flags.
// RL9: With the watchdog selected, halt is executed as idle.
// RL10: Long jump and call carry a 12-bit absolute address, two bytes, four cycles, keep flags.
// RL11: Low nibbles 0,2,4,6 decode as the four flag branches, 1 as call, and 04h as no-op.
// RL12: Low nibble 3 gives clear-test on even high nibbles, high-test on odd, bit order 0,4,2,6,1,5,3,7.
// RL13: Unused opcode positions decode as illegal, apart from every valid encoding.
// RL14: Call pushes the next address on the return stack and both exits restore the PC from it.
`timescale 1ns/10ps
`default_nettype none
module bbd_core
    import bbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] pm_data_i,
    input wire logic [7:0] dm_rdata_i,
    input wire logic wdog_sel_i,
    input wire logic wake_i,
    input wire logic ext_done_i,
    input wire logic [11:0] ext_pc_i,
    input wire bbd_flags_t interrupt_exit_instr_flags_i,
    output logic [11:0] pm_addr_o,
    output bbd_dm_req_t dm_req_o,
    output bbd_flags_t flags_o,
    output logic [7:0] opcode_o,
    output logic illegal_o,
    output logic halt_o,
    output logic idle_o,
    output logic foreign_o
);
    // ==========================================================
    // Decode
    function automatic bbd_class_t decode(input logic [7:0] op);
        bbd_class_t cls;
        cls = CL_FOREIGN;
        if (op == OPC_NOP) begin
            cls = CL_NOP; // [RL11]
        end else if (op == OPC_SUB_EXIT) begin
            cls = CL_SUB_EXIT;
        end else if (op == OPC_INT_EXIT) begin
            cls = CL_INT_EXIT;
        end else if (op == OPC_HALT) begin
            cls = CL_HALT;
        end else if (op == OPC_IDLE) begin
            cls = CL_IDLE;
        end else if (op[0] == 1'b0) begin
            cls = CL_BRANCH; // [RL11]
        end else if (op[3:0] == LO_CALL) begin
            cls = CL_CALL; // [RL11]
        end else if (op[3:0] == LO_JUMP) begin
            cls = CL_JUMP;
        end else if (op[3:0] == LO_BTEST) begin
            cls = CL_BTEST; // [RL12]
        end else if (op[3:0] == LO_BITOP) begin
            cls = CL_BITOP;
        end else if ((op[3:0] == LO_HOLE_A && op[4] == 1'b0)
                     || (op[3:0] == LO_HOLE_B && (op[7:4] == 4'h7 || op[7:4] == 4'h9
                                                  || op[7:4] == 4'hf))) begin
            cls = CL_ILLEGAL; // [RL13]
        end
        return cls;
    endfunction

    function automatic logic [2:0] last_step(input bbd_class_t cls);
        logic [2:0] n;
        case (cls)
            CL_BTEST: n = LAST_BTEST;
            CL_BITOP, CL_JUMP, CL_CALL: n = LAST_LONG;
            default: n = LAST_SHORT;
        endcase
        return n;
    endfunction

    // ==========================================================
    // State
    bbd_state_t state, next_state;
    bbd_class_t cls, next_cls;
    logic [11:0] pc, next_pc;
    logic [11:0] pm_addr, next_pm_addr;
    logic [2:0] step, next_step;
    logic [7:0] opcode, next_opcode;
    logic [7:0] op1, next_op1;
    logic [7:0] op2, next_op2;
    logic [7:0] rbyte, next_rbyte;
    bbd_flags_t flags, next_flags;
    bbd_dm_req_t dm_req, next_dm_req;
    logic illegal, next_illegal;
    logic halt, next_halt;
    logic idle, next_idle;
    logic foreign, next_foreign;

    logic push, pop;
    logic [11:0] stk_top;
    bbd_class_t fetch_cls;
    logic [2:0] bitsel;
    logic cond_ok;
    logic bit_val;
    logic [11:0] pc_plus2;
    logic [11:0] br_target;
    logic [11:0] bt_target;
    logic final_step;

    assign fetch_cls = decode(pm_data_i);
    // Bit number is the high-nibble pair index, reversed
    assign bitsel = {opcode[5], opcode[6], opcode[7]}; // [RL5] [RL12]
    assign bit_val = rbyte[bitsel];
    assign pc_plus2 = pc + PC_TWO;
    assign br_target = pc + PC_ONE + {{7{opcode[7]}}, opcode[7:3]}; // [RL2]
    assign bt_target = pc + PC_TWO + {{4{op2[7]}}, op2}; // [RL3]
    assign final_step = (state == ST_EXEC) && (step == last_step(cls));

    always_comb begin
        case (opcode[2:1])
            CND_NONZERO: cond_ok = !flags.z;
            CND_NO_CARRY: cond_ok = !flags.c;
            CND_ZERO: cond_ok = flags.z;
            CND_CARRY: cond_ok = flags.c;
            default: cond_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        next_cls = cls;
        next_pc = pc;
        next_pm_addr = pm_addr;
        next_step = step;
        next_opcode = opcode;
        next_op1 = op1;
        next_op2 = op2;
        next_rbyte = rbyte;
        next_flags = flags;
        next_dm_req = dm_req;
        next_dm_req.we = 1'b0;
        next_illegal = 1'b0;
        next_halt = 1'b0;
        next_idle = 1'b0;
        next_foreign = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        case (state)
            ST_FETCH: begin
                next_opcode = pm_data_i;
                next_cls = fetch_cls;
                next_step = 3'h1;
                next_pm_addr = pc + PC_ONE;
                if (fetch_cls == CL_FOREIGN) begin
                    // Other decoders own this opcode; wait for their new PC
                    next_foreign = 1'b1;
                    next_state = ST_EXT;
                end else begin
                    next_illegal = (fetch_cls == CL_ILLEGAL); // [RL13]
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_step = step + 3'h1;
                if (step == 3'h1) begin
                    next_op1 = pm_data_i;
                    next_pm_addr = pc + PC_TWO;
                    next_dm_req.addr = pm_data_i; // [RL6]
                end
                if (step == 3'h2) begin
                    next_op2 = pm_data_i;
                    next_rbyte = dm_rdata_i;
                end
                if (final_step) begin
                    next_state = ST_FETCH;
                    next_pc = pc + PC_ONE;
                    case (cls)
                        CL_BRANCH: next_pc = cond_ok ? br_target : pc + PC_ONE; // [RL1]
                        CL_BTEST: begin
                            next_flags.c = bit_val; // [RL4]
                            next_pc = (bit_val == opcode[4]) ? bt_target : pc + PC_THREE; // [RL3]
                        end
                        CL_BITOP: begin
                            // Whole byte is rewritten, so volatile bits get the read value
                            next_dm_req.wdata = rbyte; // [RL7]
                            next_dm_req.wdata[bitsel] = opcode[4]; // [RL6]
                            next_dm_req.we = 1'b1;
                            next_pc = pc_plus2;
                        end
                        CL_JUMP: next_pc = {opcode[7:4], op1}; // [RL10]
                        CL_CALL: begin
                            push = 1'b1; // [RL14]
                            next_pc = {opcode[7:4], op1}; // [RL10]
                        end
                        CL_SUB_EXIT: begin
                            pop = 1'b1; // [RL14]
                            next_pc = stk_top;
                        end
                        CL_INT_EXIT: begin
                            pop = 1'b1; // [RL14]
                            next_pc = stk_top;
                            next_flags = interrupt_exit_instr_flags_i; // [RL8]
                        end
                        CL_HALT: begin
                            next_halt = !wdog_sel_i; // [RL9]
                            next_idle = wdog_sel_i; // [RL9]
                            next_state = ST_SLEEP;
                        end
                        CL_IDLE: begin
                            next_idle = 1'b1;
                            next_state = ST_SLEEP;
                        end
                        default: next_pc = pc + PC_ONE;
                    endcase
                    next_pm_addr = next_pc;
                end
            end
            ST_SLEEP: next_state = wake_i ? ST_FETCH : ST_SLEEP;
            ST_EXT: begin
                if (ext_done_i) begin
                    next_pc = ext_pc_i;
                    next_pm_addr = ext_pc_i;
                    next_state = ST_FETCH;
                end
            end
            default: next_state = ST_FETCH;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_FETCH;
            cls <= CL_NOP;
            pc <= PC_RESET;
            pm_addr <= PC_RESET;
            step <= 3'h0;
            opcode <= 8'h00;
            op1 <= 8'h00;
            op2 <= 8'h00;
            rbyte <= 8'h00;
            flags <= '0;
            dm_req <= '0;
            illegal <= 1'b0;
            halt <= 1'b0;
            idle <= 1'b0;
            foreign <= 1'b0;
        end else begin
            state <= next_state;
            cls <= next_cls;
            pc <= next_pc;
            pm_addr <= next_pm_addr;
            step <= next_step;
            opcode <= next_opcode;
            op1 <= next_op1;
            op2 <= next_op2;
            rbyte <= next_rbyte;
            flags <= next_flags;
            dm_req <= next_dm_req;
            illegal <= next_illegal;
            halt <= next_halt;
            idle <= next_idle;
            foreign <= next_foreign;
        end
    end

    bbd_ret_stack #(
        .DEPTH(STACK_DEPTH),
        .W(PC_W)
    ) u_stack (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .push_i(push),
        .pop_i(pop),
        .data_i(pc_plus2),
        .top_o(stk_top)
    );

    assign pm_addr_o = pm_addr;
    assign dm_req_o = dm_req;
    assign flags_o = flags;
    assign opcode_o = opcode;
    assign illegal_o = illegal;
    assign halt_o = halt;
    assign idle_o = idle;
    assign foreign_o = foreign;

    // ==========================================================
    // Checks
    logic [11:0] pc_hist;
    logic [11:0] pc_delta;
    always_ff @(posedge clk_i) begin
        pc_hist <= pc;
    end
    assign pc_delta = pc - pc_hist;

    a_branch_two: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL1]
        (state == ST_FETCH && fetch_cls == CL_BRANCH) |=> (state == ST_EXEC)
            ##1 (state == ST_FETCH && $stable(flags)))
        else $error("flag branch not two cycles or flags moved");
    // Delta is valid only one edge after the branch, before the history catches up
    a_branch_reach: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL2]
        (final_step && cls == CL_BRANCH) |=>
            ($signed(pc_delta) >= -15 && $signed(pc_delta) <= 16))
        else $error("flag branch target out of reach");
    a_btest_five: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL3]
        (state == ST_FETCH && fetch_cls == CL_BTEST) |=> (state == ST_EXEC) [*4]
            ##1 (state == ST_FETCH))
        else $error("bit-test branch not five cycles");
    a_btest_carry: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL4]
        (final_step && cls == CL_BTEST) |=>
            (flags.c == $past(bit_val) && flags.z == $past(flags.z)))
        else $error("tested bit not in carry or zero moved");
    a_bitop_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL6]
        (state == ST_FETCH && fetch_cls == CL_BITOP) |=> ##3
            (dm_req.we && dm_req.wdata[bitsel] == opcode[4] && $stable(flags)))
        else $error("bit set or clear write wrong or late");
    a_ctrl_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL8]
        (final_step && (cls == CL_NOP || cls == CL_SUB_EXIT || cls == CL_HALT
                        || cls == CL_IDLE)) |=> $stable(flags))
        else $error("control instruction changed flags");
    a_halt_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL9]
        (final_step && cls == CL_HALT && wdog_sel_i) |=> (idle_o && !halt_o))
        else $error("halt not turned into idle under watchdog");
    a_jump_abs: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL10]
        (final_step && (cls == CL_JUMP || cls == CL_CALL)) |=>
            (pc == {opcode[7:4], op1} && pm_addr_o == pc))
        else $error("long jump target wrong");
    a_illegal_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL13]
        (state == ST_FETCH && pm_data_i == 8'h05) |=> illegal_o ##1 !illegal_o)
        else $error("unused opcode not flagged");
    a_call_return: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL14]
        (final_step && cls == CL_CALL) |=> (stk_top == $past(pc_plus2)))
        else $error("call did not save the return address");
endmodule
`default_nettype wire

// File: hw/bbd_pkg.sv
// Shared constants and types for the branch, bit and control decoder
package bbd_pkg;

    // ==========================================================
    // Widths and opcode fields
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 6;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [11:0] PC_ONE = 12'h001;
    localparam logic [11:0] PC_TWO = 12'h002;
    localparam logic [11:0] PC_THREE = 12'h003;
    localparam logic [3:0] LO_CALL = 4'h1;
    localparam logic [3:0] LO_JUMP = 4'h9;
    localparam logic [3:0] LO_BTEST = 4'h3;
    localparam logic [3:0] LO_BITOP = 4'hb;
    localparam logic [3:0] LO_HOLE_A = 4'h5;
    localparam logic [3:0] LO_HOLE_B = 4'h7;
    localparam logic [1:0] CND_NONZERO = 2'h0;
    localparam logic [1:0] CND_NO_CARRY = 2'h1;
    localparam logic [1:0] CND_ZERO = 2'h2;
    localparam logic [1:0] CND_CARRY = 2'h3;

    // ==========================================================
    // Fixed opcodes
    localparam logic [7:0] OPC_NOP = 8'h04;
    localparam logic [7:0] OPC_SUB_EXIT = 8'hcd;
    localparam logic [7:0] OPC_INT_EXIT = 8'h4d;
    localparam logic [7:0] OPC_HALT = 8'h6d;
    localparam logic [7:0] OPC_IDLE = 8'hed;

    // ==========================================================
    // Last execute step of each class (cycles minus the fetch cycle)
    localparam logic [2:0] LAST_SHORT = 3'h1;
    localparam logic [2:0] LAST_LONG = 3'h3;
    localparam logic [2:0] LAST_BTEST = 3'h4;

    // ==========================================================
    // Types
    typedef struct packed {
        logic z;
        logic c;
    } bbd_flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
    } bbd_dm_req_t;

    typedef enum logic [3:0] {
        CL_BRANCH = 4'b0000,
        CL_BTEST = 4'b0001,
        CL_BITOP = 4'b0010,
        CL_JUMP = 4'b0011,
        CL_CALL = 4'b0100,
        CL_NOP = 4'b0101,
        CL_SUB_EXIT = 4'b0110,
        CL_INT_EXIT = 4'b0111,
        CL_HALT = 4'b1000,
        CL_IDLE = 4'b1001,
        CL_ILLEGAL = 4'b1010,
        CL_FOREIGN = 4'b1011
    } bbd_class_t;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_EXEC = 2'b01,
        ST_SLEEP = 2'b10,
        ST_EXT = 2'b11
    } bbd_state_t;

endpackage

// File: hw/bbd_ret_stack.sv
// Hardware return stack for subroutine and interrupt exits
`timescale 1ns/10ps
`default_nettype none
module bbd_ret_stack #(
    parameter int DEPTH = 6,
    parameter int W = 12
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [W-1:0] data_i,
    output logic [W-1:0] top_o
);
    // ==========================================================
    // Storage and pointer
    localparam int SP_W = $clog2(DEPTH + 1);
    localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);
    localparam logic [SP_W-1:0] SP_LAST = SP_W'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [SP_W-1:0] sp;
    logic [SP_W-1:0] next_sp;
    logic [SP_W-1:0] top_idx;

    // Overflow wraps onto the oldest entry, as software nests too deep
    always_comb begin
        next_sp = sp;
        if (push_i) begin
            next_sp = (sp == SP_LAST) ? '0 : sp + SP_ONE;
        end else if (pop_i) begin
            next_sp = (sp == '0) ? SP_LAST : sp - SP_ONE;
        end
    end

    assign top_idx = (sp == '0) ? SP_LAST : sp - SP_ONE;
    assign top_o = mem[top_idx];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sp <= '0;
        end else begin
            sp <= next_sp;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push_i) begin
            mem[sp] <= data_i;
        end
    end
endmodule
`default_nettype wire
